//--- core/msb_consts.svh
// Constants of the microsequence branch select: field codes and widths.
// Assumes inclusion by msb_pkg and the design module only.
`ifndef MSB_CONSTS_SVH
`define MSB_CONSTS_SVH

// Field widths of the microinstruction parts this block decodes, and width of the K and N counters
`define MSB_TEST_W      3
`define MSB_SPECIAL_W   4
`define MSB_CONST_W     8
`define MSB_COUNT_W     8
`define MSB_BITSEL_W    5

// Primary test codes (alternate set bit clear)
`define MSB_T_HERE_LOWER   3'h0
`define MSB_T_UPPER        3'h1
`define MSB_T_LOWER        3'h2
`define MSB_T_K_ZERO       3'h3
`define MSB_T_N_ZERO       3'h4
`define MSB_T_IRQ          3'h5
`define MSB_T_NEGATIVE     3'h6
`define MSB_T_ZERO         3'h7

// Alternate test codes (alternate set bit set)
`define MSB_A_HERE_LOWER   3'h0
`define MSB_A_Q_LSB        3'h1
`define MSB_A_K_LSB        3'h2
`define MSB_A_OVERFLOW     3'h3
`define MSB_A_WIRED_BIT    3'h4
`define MSB_A_Q_PART_LSB   3'h5
`define MSB_A_CARRY        3'h6
`define MSB_A_PART_ZERO    3'h7

// Special commands handled here
`define MSB_S_REPEAT       4'h2
`define MSB_S_MEM_READ     4'h3

// Reset values
`define MSB_RST_ADDR_BUF   32'h0000_0000
`define MSB_RST_UPPER      1'b1

`endif

//--- core/msb_pkg.sv
// Types of the microsequence branch select.
// Assumes msb_consts.svh is on the include path.
`include "msb_consts.svh"

package msb_pkg;

  // Fields of the current microinstruction that steer the selection
  typedef struct packed {
    logic [`MSB_TEST_W-1:0]    testCode;
    logic                      altTestSet;
    logic [`MSB_SPECIAL_W-1:0] specialCode;
    logic [`MSB_CONST_W-1:0]   constField;
  } msb_uinstr_t;

  // Datapath conditions presented during the current cycle
  typedef struct packed {
    logic aluSign;
    logic aluZero;
    logic aluCarry;
    logic overflow;
    logic qLsb;
    logic qPartnerLsb;
    logic aluPartnerZero;
  } msb_cond_t;

  typedef enum logic [0:0] {
    MSB_RUN  = 1'b0,
    MSB_WAIT = 1'b1
  } msb_state_t;

endpackage

//--- core/msb_branch_select.sv
// Next-microinstruction select of a microprogrammed processor: test field
// decode, repeat command and main-memory read stall with address buffer.
// Assumes one clock, all inputs synchronous, and separate addressing-mode
// logic that supplies the mode pair address each cycle.
//
// Function
// - Test field picks upper or lower half of next pair, with or without test.
// - Micromemory data access: test field feeds address, next sequential upper.
// - Bit 24 clear picks primary test set, set picks alternate set.
// - Alternate set honoured only in return and sequential addressing modes.
// - Code 000 runs lower half of current pair, overriding addressing mode.
// - Unconditional codes pick upper or lower half of next pair.
// - Code 011 picks upper when K was zero at cycle start.
// - Code 100 picks upper when N was zero at cycle start.
// - Code 101 picks upper when any masked-in interrupt is active.
// - Code 110 picks upper when this cycle's ALU result is negative.
// - Code 111 picks lower when this cycle's ALU result is zero.
// - Alternate 001/101 pick lower when Q or partner LSB is one.
// - Alternate 010 picks lower when K least significant bit is set.
// - Alternate 011 picks lower when arithmetic overflow exists.
// - Alternate 100 tests wired bit chosen by constant low five bits.
// - Alternate 110 picks lower when the ALU produced a carry out.
// - Alternate 111 picks lower when secondary ALU result is zero.
// - Repeat: N nonzero reruns current pair and decrements N; else normal.
// - Memory read uses address buffer and stalls until memory resume.
// - Buffer reload issued with a read lands only after the read completes.
`timescale 1ns/100ps
`include "msb_consts.svh"

module msb_branch_select
  import msb_pkg::*;
#(
  parameter int PAIR_W  = 12,
  parameter int IRQ_W   = 16,
  parameter int WIRED_W = 32,
  parameter int ADDR_W  = 32
)(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    instrValid,
  input  wire msb_uinstr_t             uInstr,
  input  wire logic                    altModeOk,
  input  wire logic                    mmDataAccess,
  input  wire msb_cond_t               cond,
  input  wire logic [`MSB_COUNT_W-1:0] kCount,
  input  wire logic [`MSB_COUNT_W-1:0] nCount,
  input  wire logic [IRQ_W-1:0]        irqActive,
  input  wire logic [IRQ_W-1:0]        irqMask,
  input  wire logic [WIRED_W-1:0]      wiredBits,
  input  wire logic [PAIR_W-1:0]       curPair,
  input  wire logic [PAIR_W-1:0]       seqPair,
  input  wire logic [PAIR_W-1:0]       modePair,
  input  wire logic                    addrBufLoad,
  input  wire logic [ADDR_W-1:0]       addrBufData,
  input  wire logic                    memResume,
  output logic                         fetchValid_q,
  output logic [PAIR_W-1:0]            fetchPair_q,
  output logic                         fetchUpper_q,
  output logic [`MSB_TEST_W-1:0]       mmAddrPart_q,
  output logic                         nDecrement_q,
  output logic                         memReadReq_q,
  output logic [ADDR_W-1:0]            memAddrBuf_q,
  output logic                         stall_q
);

  msb_state_t               state_q;
  msb_state_t               state_d;
  logic                     fetchValid_d;
  logic [PAIR_W-1:0]        fetchPair_d;
  logic                     fetchUpper_d;
  logic [`MSB_TEST_W-1:0]   mmAddrPart_d;
  logic                     nDecrement_d;
  logic                     memReadReq_d;
  logic [ADDR_W-1:0]        memAddrBuf_d;
  logic                     stall_d;
  logic                     pendLoad_q;
  logic                     pendLoad_d;
  logic [ADDR_W-1:0]        pendData_q;
  logic [ADDR_W-1:0]        pendData_d;
  logic [PAIR_W-1:0]        heldPair_q;
  logic [PAIR_W-1:0]        heldPair_d;
  logic                     heldUpper_q;
  logic                     heldUpper_d;
  logic                     heldDec_q;
  logic                     heldDec_d;

  logic                     useAlt;
  logic                     takeUpper;
  logic                     hereLower;
  logic                     irqPending;
  logic                     wiredBit;
  logic                     repeatPair;
  logic                     readCmd;
  logic [PAIR_W-1:0]        selPair;
  logic                     selUpper;

  // Interrupt summary and wired bit selector feed the test decode
  assign irqPending = |(irqActive & irqMask);
  assign wiredBit   = wiredBits[uInstr.constField[`MSB_BITSEL_W-1:0]];
  assign readCmd    = uInstr.specialCode == `MSB_S_MEM_READ;

  // Test field decode; counters are taken as they stood at cycle start
  always_comb
  begin
    useAlt    = uInstr.altTestSet && altModeOk;
    takeUpper = 1'b1;
    hereLower = uInstr.testCode == `MSB_T_HERE_LOWER;
    if (!useAlt)
    begin
      unique case (uInstr.testCode)
        `MSB_T_HERE_LOWER: takeUpper = 1'b0;
        `MSB_T_UPPER:      takeUpper = 1'b1;
        `MSB_T_LOWER:      takeUpper = 1'b0;
        `MSB_T_K_ZERO:     takeUpper = kCount == '0;
        `MSB_T_N_ZERO:     takeUpper = nCount == '0;
        `MSB_T_IRQ:        takeUpper = irqPending;
        `MSB_T_NEGATIVE:   takeUpper = cond.aluSign;
        `MSB_T_ZERO:       takeUpper = !cond.aluZero;
      endcase
    end
    else
    begin
      unique case (uInstr.testCode)
        `MSB_A_HERE_LOWER: takeUpper = 1'b0;
        `MSB_A_Q_LSB:      takeUpper = !cond.qLsb;
        `MSB_A_K_LSB:      takeUpper = !kCount[0];
        `MSB_A_OVERFLOW:   takeUpper = !cond.overflow;
        `MSB_A_WIRED_BIT:  takeUpper = wiredBit;
        `MSB_A_Q_PART_LSB: takeUpper = !cond.qPartnerLsb;
        `MSB_A_CARRY:      takeUpper = !cond.aluCarry;
        `MSB_A_PART_ZERO:  takeUpper = !cond.aluPartnerZero;
      endcase
    end
  end

  // Pair selection; micromemory access outranks every test code
  always_comb
  begin
    repeatPair = uInstr.specialCode == `MSB_S_REPEAT && nCount != '0;
    if (mmDataAccess)
    begin
      selPair  = seqPair;
      selUpper = 1'b1;
    end
    else if (hereLower)
    begin
      selPair  = curPair;
      selUpper = 1'b0;
    end
    else if (repeatPair)
    begin
      selPair  = curPair;
      selUpper = takeUpper;
    end
    else
    begin
      selPair  = modePair;
      selUpper = takeUpper;
    end
  end

  // Sequencer next state: issue, stall on read, release on resume
  always_comb
  begin
    state_d      = state_q;
    fetchValid_d = 1'b0;
    fetchPair_d  = fetchPair_q;
    fetchUpper_d = fetchUpper_q;
    mmAddrPart_d = mmAddrPart_q;
    nDecrement_d = 1'b0;
    memReadReq_d = memReadReq_q;
    memAddrBuf_d = memAddrBuf_q;
    stall_d      = stall_q;
    pendLoad_d   = pendLoad_q;
    pendData_d   = pendData_q;
    heldPair_d   = heldPair_q;
    heldUpper_d  = heldUpper_q;
    heldDec_d    = heldDec_q;
    unique case (state_q)
      MSB_RUN:
      begin
        if (instrValid && readCmd && !mmDataAccess)
        begin
          // Decision is taken now, while its conditions are current
          state_d      = MSB_WAIT;
          memReadReq_d = 1'b1;
          stall_d      = 1'b1;
          heldPair_d   = selPair;
          heldUpper_d  = selUpper;
          heldDec_d    = repeatPair;
          pendLoad_d   = addrBufLoad;
          pendData_d   = addrBufData;
        end
        else if (instrValid)
        begin
          fetchValid_d = 1'b1;
          fetchPair_d  = selPair;
          fetchUpper_d = selUpper;
          nDecrement_d = repeatPair;
          if (mmDataAccess)
          begin
            mmAddrPart_d = uInstr.testCode;
          end
          if (addrBufLoad)
          begin
            memAddrBuf_d = addrBufData;
          end
        end
      end
      MSB_WAIT:
      begin
        // New instructions are ignored until memory answers
        if (memResume)
        begin
          state_d      = MSB_RUN;
          memReadReq_d = 1'b0;
          stall_d      = 1'b0;
          fetchValid_d = 1'b1;
          fetchPair_d  = heldPair_q;
          fetchUpper_d = heldUpper_q;
          nDecrement_d = heldDec_q;
          pendLoad_d   = 1'b0;
          if (pendLoad_q)
          begin
            memAddrBuf_d = pendData_q;
          end
        end
      end
    endcase
  end

  // Sequencer state and read handshake levels
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= MSB_RUN;
      memReadReq_q <= 1'b0;
      stall_q      <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      memReadReq_q <= memReadReq_d;
      stall_q      <= stall_d;
    end
  end

  // Decision and reload kept across a read, so late condition changes cannot leak in
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pendLoad_q   <= 1'b0;
      pendData_q   <= '0;
      heldPair_q   <= '0;
      heldUpper_q  <= `MSB_RST_UPPER;
      heldDec_q    <= 1'b0;
    end
    else
    begin
      pendLoad_q   <= pendLoad_d;
      pendData_q   <= pendData_d;
      heldPair_q   <= heldPair_d;
      heldUpper_q  <= heldUpper_d;
      heldDec_q    <= heldDec_d;
    end
  end

  // Fetch outputs; every one is a flop so the control store sees clean timing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fetchValid_q <= 1'b0;
      fetchPair_q  <= '0;
      fetchUpper_q <= `MSB_RST_UPPER;
      mmAddrPart_q <= '0;
      nDecrement_q <= 1'b0;
    end
    else
    begin
      fetchValid_q <= fetchValid_d;
      fetchPair_q  <= fetchPair_d;
      fetchUpper_q <= fetchUpper_d;
      mmAddrPart_q <= mmAddrPart_d;
      nDecrement_q <= nDecrement_d;
    end
  end

  // Address buffer; a reload paired with a read waits for the read to finish
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      memAddrBuf_q <= ADDR_W'(`MSB_RST_ADDR_BUF);
    end
    else
    begin
      memAddrBuf_q <= memAddrBuf_d;
    end
  end

endmodule

//--- testbench/msb_branch_select_checker.sv
// Port checker of the branch select: answer timing, priorities, repeat, read stall.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps

module msb_branch_select_checker
  import msb_pkg::*;
#(
  parameter int PAIR_W = 12,
  parameter int ADDR_W = 32
)(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              instrValid,
  input wire msb_uinstr_t       uInstr,
  input wire logic              mmDataAccess,
  input wire logic [7:0]        nCount,
  input wire logic [PAIR_W-1:0] curPair,
  input wire logic [PAIR_W-1:0] seqPair,
  input wire logic              addrBufLoad,
  input wire logic [ADDR_W-1:0] addrBufData,
  input wire logic              memResume,
  input wire logic              fetchValid_q,
  input wire logic [PAIR_W-1:0] fetchPair_q,
  input wire logic              fetchUpper_q,
  input wire logic [2:0]        mmAddrPart_q,
  input wire logic              nDecrement_q,
  input wire logic              memReadReq_q,
  input wire logic [ADDR_W-1:0] memAddrBuf_q,
  input wire logic              stall_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Requests count only outside a read stall
  wire take  = instrValid && !stall_q;
  wire rdCmd = take && uInstr.specialCode == 4'h3 && !mmDataAccess;
  wire plain = take && !rdCmd && !mmDataAccess;
  sequence s_wait; stall_q && !memResume; endsequence
  sequence s_done; stall_q && memResume; endsequence
  property p_answer; take && !rdCmd |=> fetchValid_q; endproperty
  a_answer: assert property (p_answer) else $error("no fetch after request");
  property p_mm; take && mmDataAccess |=> fetchUpper_q && fetchPair_q == $past(seqPair)
    && mmAddrPart_q == $past(uInstr.testCode); endproperty
  a_mm: assert property (p_mm) else $error("bad micromemory access fetch");
  property p_here; plain && uInstr.testCode == 3'h0
    |=> !fetchUpper_q && fetchPair_q == $past(curPair); endproperty
  a_here: assert property (p_here) else $error("bad lower of current pair");
  property p_rpt; plain && uInstr.testCode != 3'h0 && uInstr.specialCode == 4'h2
    && nCount != 8'h00 |=> nDecrement_q && fetchPair_q == $past(curPair); endproperty
  a_rpt: assert property (p_rpt) else $error("repeat did not rerun pair");
  property p_dec; take && uInstr.specialCode != 4'h2 |=> !nDecrement_q; endproperty
  a_dec: assert property (p_dec) else $error("decrement without repeat");
  property p_issue; rdCmd |=> memReadReq_q && stall_q; endproperty
  a_issue: assert property (p_issue) else $error("read not issued");
  property p_hold; s_wait |=> stall_q && !fetchValid_q && $stable(memAddrBuf_q); endproperty
  a_hold: assert property (p_hold) else $error("stall released early");
  property p_done; s_done |=> !stall_q && !memReadReq_q && fetchValid_q; endproperty
  a_done: assert property (p_done) else $error("resume not honoured");
  property p_load; plain && addrBufLoad |=> memAddrBuf_q == $past(addrBufData); endproperty
  a_load: assert property (p_load) else $error("buffer load lost");
endmodule

bind msb_branch_select msb_branch_select_checker #(.PAIR_W(PAIR_W), .ADDR_W(ADDR_W)) i_chk (.*);

//--- testbench/msb_mem_model.sv
// Main memory model: answers each pending read with a one-cycle resume.
// Assumes the request stays high until its resume has been seen.
`timescale 1ns/100ps

module msb_mem_model
  import msb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       readReq,
  input  wire logic [3:0] delay,
  output logic            memResume
);
  logic [3:0] waitCnt;

  // Falling edge drive, so the design samples a settled resume
  always @(negedge clk or posedge rst)
    if (rst)
    begin
      waitCnt <= 4'h0;
      memResume <= 1'b0;
    end
    else if (memResume)
    begin
      memResume <= 1'b0;
      waitCnt <= 4'h0;
    end
    else if (readReq)
      if (waitCnt == delay)
        memResume <= 1'b1;
      else
        waitCnt <= waitCnt + 4'h1;
endmodule

//--- testbench/test_msb_branch_select.sv
// Testbench of the branch select: test code table, repeat, micromemory access, reads.
// Assumes the memory model answers a read after a set number of cycles.
`timescale 1ns/100ps

module test_msb_branch_select
  import msb_pkg::*;
;
  logic        clk, rst, instrValid, altModeOk, mmDataAccess, addrBufLoad, memResume, alt;
  msb_uinstr_t uInstr;
  msb_cond_t   cond;
  logic [7:0]  kCount, nCount;
  logic [15:0] irqActive, irqMask;
  logic [31:0] wiredBits, addrBufData, memAddrBuf_q;
  logic [11:0] curPair, seqPair, modePair, fetchPair_q;
  logic        fetchValid_q, fetchUpper_q, nDecrement_q, memReadReq_q, stall_q;
  logic [2:0]  mmAddrPart_q;
  logic [3:0]  delay;
  int          fails, checks;

  msb_branch_select i_msb_branch_select (.*);
  msb_mem_model i_msb_mem_model (.clk, .rst, .readReq(memReadReq_q), .delay, .memResume);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Only the condition of code s (set bit 3) points to upper when v; all others point away,
  // so a code wired to the wrong condition shows up. Counters stay fixed, never incremented
  task automatic setv(input logic v, input int s);
    cond = {s == 6 ? v : !v, s == 7 ? !v : v, s == 14 ? !v : v, s == 11 ? !v : v,
            s == 9 ? !v : v, s == 13 ? !v : v, s == 15 ? !v : v};
    kCount = s == 3 ? (v ? 8'h00 : 8'h02) : s == 10 ? (v ? 8'h02 : 8'h01) : {7'h00, v};
    nCount = s == 4 ? {7'h00, !v} : {7'h00, v};
    irqActive = (s == 5) == v ? 16'h0001 : 16'h0002;
    wiredBits = (s == 12) == v ? 32'h0000_0200 : 32'hffff_fdff;
  endtask

  // One instruction; its answer is registered at the taking edge
  task automatic issue(input logic [3:0] s, input logic [2:0] t, input logic [11:0] p,
                       input logic up, input logic dec);
    @(negedge clk);
    uInstr = {t, alt, s, 8'h09};
    instrValid = 1'b1;
    @(negedge clk);
    instrValid = 1'b0;
    chk("fetchValid", 1, fetchValid_q);
    chk("fetchPair", p, fetchPair_q);
    chk("fetchUpper", up, fetchUpper_q);
    chk("nDecrement", dec, nDecrement_q);
  endtask

  // Read with a buffer reload in the same instruction; the next fetch follows it
  task automatic rd(input logic [3:0] d, input logic [31:0] oldB, input logic [31:0] newB);
    int n;
    n = 0;
    delay = d;
    addrBufData = newB;
    @(negedge clk);
    uInstr = {3'h1, 1'b0, 4'h3, 8'h09};
    instrValid = 1'b1;
    addrBufLoad = 1'b1;
    @(negedge clk);
    instrValid = 1'b0;
    addrBufLoad = 1'b0;
    chk("memReadReq", 1, memReadReq_q);
    while (fetchValid_q !== 1'b1 && n < 20)
    begin
      chk("stall", 1, stall_q);
      chk("memAddrBufHold", oldB, memAddrBuf_q);
      @(negedge clk);
      n++;
    end
    chk("readWait", d + 1, n);
    chk("memAddrBuf", newB, memAddrBuf_q);
    chk("stallEnd", 0, stall_q);
    chk("memReadReqEnd", 0, memReadReq_q);
    chk("readUpper", 1, fetchUpper_q);
  endtask

  initial
  begin
    {rst, instrValid, altModeOk, mmDataAccess, addrBufLoad, alt} = 6'h20;
    uInstr = '0;
    setv(1'b0, 0);
    irqMask = 16'h0001;
    curPair = 12'h111;
    seqPair = 12'h222;
    modePair = 12'h333;
    addrBufData = 32'h0000_1234;
    delay = 4'h0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk("fetchUpperRst", 1, fetchUpper_q);
    chk("stallRst", 0, stall_q);
    // Every code of both sets, with its condition both ways
    altModeOk = 1'b1;
    for (int s = 0; s < 16; s++)
      for (int v = 0; v < 2; v++)
      begin
        alt = s[3];
        setv(v[0], s);
        if (s[2:0] == 3'h0)
          issue(4'h0, 3'h0, 12'h111, 1'b0, 1'b0);
        else if (s < 3)
          issue(4'h0, s[2:0], 12'h333, s == 1, 1'b0);
        else if (s < 8)
          issue(4'h0, s[2:0], 12'h333, v[0], 1'b0);
        else
          issue(4'h0, s[2:0], 12'h333, v[0], 1'b0);
      end
    // K low bit clear: an honoured alternate code 010 would pick upper here
    setv(1'b1, 10);
    altModeOk = 1'b0;
    issue(4'h0, 3'h2, 12'h333, 1'b0, 1'b0);
    alt = 1'b0;
    mmDataAccess = 1'b1;
    issue(4'h0, 3'h5, 12'h222, 1'b1, 1'b0);
    chk("mmAddrPart", 5, mmAddrPart_q);
    mmDataAccess = 1'b0;
    setv(1'b1, 6);
    nCount = 8'h03;
    issue(4'h2, 3'h6, 12'h111, 1'b1, 1'b1);
    nCount = 8'h00;
    issue(4'h2, 3'h6, 12'h333, 1'b1, 1'b0);
    addrBufLoad = 1'b1;
    issue(4'h0, 3'h1, 12'h333, 1'b1, 1'b0);
    addrBufLoad = 1'b0;
    chk("memAddrBufLoad", 32'h0000_1234, memAddrBuf_q);
    rd(4'h3, 32'h0000_1234, 32'h0000_5678);
    rd(4'h0, 32'h0000_5678, 32'h0000_9abc);
    stop_test();
  end
endmodule
